/* File: core/apm_alarm_mask.sv */
`timescale 1ns/1ps
module apm_alarm_mask (
   input wire logic core_clk, // Device clock, 100 MHz
   input wire logic arst_n, // Async reset, active low
   input wire logic host_wr, // Byte write strobe
   input wire logic host_rd, // Byte read strobe
   input wire logic [7:0] host_addr, // Byte address
   input wire logic [7:0] host_wdata, // Write byte
   output logic [7:0] host_rdata, // Read byte
   output logic host_rvalid, // Read byte valid
   output logic level2_access, // Password matched
   input wire logic temp_alarm, // Temperature out of limits
   input wire logic vcc_alarm, // Supply out of limits
   input wire logic mon1_alarm, // Monitor 1 out of limits
   input wire logic mon2_alarm, // Monitor 2 out of limits
   input wire logic mon3_alarm, // Monitor 3 out of limits
   input wire logic mon4_alarm, // Monitor 4 out of limits
   input wire logic high_power_alarm, // Fast power above high
   input wire logic low_power_alarm, // Fast power below low
   input wire logic bias_high_alarm, // Fast bias above high
   input wire logic bias_max_alarm, // Fast maximum-bias alarm
   input wire logic nv_restore, // Reload pulse from NV store
   input wire logic [7:0] nv_gate_meas, // Stored gate measurement mask
   input wire logic [7:0] nv_gate_fast, // Stored gate fast mask
   input wire logic [7:0] nv_fault_meas, // Stored fault measurement mask
   output logic shutdown_gate_pin, // Laser shutdown gate
   output logic fault_pin // Transmit fault
);
   logic [7:0] gate_pin_measure_mask; // Gate measurement enables
   logic [7:0] gate_pin_fast_mask; // Gate fast enables
   logic [7:0] fault_pin_measure_mask; // Fault measurement enables
   logic [31:0] level2_password; // Stored password
   logic [31:0] pw_entry; // Host password entry
   logic [7:0] meas_vec; // Measurement alarms, mask-aligned
   logic [7:0] fast_vec; // Fast alarms, mask-aligned
   logic [7:0] next_rdata; // Read mux
   logic wr_ok; // Write may land

   // Pack alarms so bit n lines up with enable bit n
   assign meas_vec = {temp_alarm, vcc_alarm, mon1_alarm, mon2_alarm, mon3_alarm, mon4_alarm,
                      2'h0};
   assign fast_vec = {high_power_alarm, low_power_alarm, bias_high_alarm, bias_max_alarm,
                      4'h0};
   assign wr_ok = host_wr && level2_access;

   // Access flag registered; adds a cycle after a password write but keeps compare off the path
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         level2_access <= 1'b0;
      end else begin
         level2_access <= (pw_entry == level2_password);
      end
   end

   // Password entry is always writable; it is the key, not a guarded byte
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pw_entry <= apm_pkg::PW_RESET;
      end else if (host_wr) begin
         for (int i = 0; i < 4; i++) begin
            if (host_addr == apm_pkg::ENTRY_BASE_OFS + 8'(i)) begin
               pw_entry[8*(3-i) +: 8] <= host_wdata;
            end
         end
      end
   end

   // Stored password changes only under level-2 access
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         level2_password <= apm_pkg::PW_RESET;
      end else if (wr_ok) begin
         for (int i = 0; i < 4; i++) begin
            if (host_addr == apm_pkg::STORED_PW_OFS + 8'(i)) begin
               level2_password[8*(3-i) +: 8] <= host_wdata;
            end
         end
      end
   end

   // Mask bytes: NV reload wins over a host write in the same cycle
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         gate_pin_measure_mask <= apm_pkg::MASK_RESET;
         gate_pin_fast_mask <= apm_pkg::MASK_RESET;
         fault_pin_measure_mask <= apm_pkg::MASK_RESET;
      end else if (nv_restore) begin
         gate_pin_measure_mask <= nv_gate_meas & apm_pkg::MEAS_WMASK;
         gate_pin_fast_mask <= nv_gate_fast & apm_pkg::FAST_WMASK;
         fault_pin_measure_mask <= nv_fault_meas & apm_pkg::MEAS_WMASK;
      end else if (wr_ok) begin
         // Reserved bits are dropped on the way in
         if (host_addr == apm_pkg::GATE_MEAS_OFS) begin
            gate_pin_measure_mask <= host_wdata & apm_pkg::MEAS_WMASK;
         end
         if (host_addr == apm_pkg::GATE_FAST_OFS) begin
            gate_pin_fast_mask <= host_wdata & apm_pkg::FAST_WMASK;
         end
         if (host_addr == apm_pkg::FAULT_MEAS_OFS) begin
            fault_pin_measure_mask <= host_wdata & apm_pkg::MEAS_WMASK;
         end
      end
   end

   // Read mux; passwords and unmapped bytes read zero, locked reads too
   always_comb begin
      next_rdata = apm_pkg::READ_ZERO;
      if (level2_access) begin
         if (host_addr == apm_pkg::GATE_MEAS_OFS) begin
            next_rdata = gate_pin_measure_mask;
         end else if (host_addr == apm_pkg::GATE_FAST_OFS) begin
            next_rdata = gate_pin_fast_mask;
         end else if (host_addr == apm_pkg::FAULT_MEAS_OFS) begin
            next_rdata = fault_pin_measure_mask;
         end
      end
   end

   // Read answer one cycle after the strobe
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         host_rdata <= apm_pkg::READ_ZERO;
         host_rvalid <= 1'b0;
      end else begin
         host_rvalid <= host_rd;
         if (host_rd) begin
            host_rdata <= next_rdata;
         end
      end
   end

   // Gate pin sees both slow and fast alarms
   apm_pin_drive u_gate (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .meas_mask(gate_pin_measure_mask),
      .fast_mask(gate_pin_fast_mask),
      .meas_alarm(meas_vec),
      .fast_alarm(fast_vec),
      .pin(shutdown_gate_pin)
   );

   // Fault pin fast mask tied to MASK_RESET (zero), so only slow alarms here
   apm_pin_drive u_fault (
      .core_clk(core_clk),
      .arst_n(arst_n),
      .meas_mask(fault_pin_measure_mask),
      .fast_mask(apm_pkg::MASK_RESET),
      .meas_alarm(meas_vec),
      .fast_alarm(fast_vec),
      .pin(fault_pin)
   );

   // Locked write to a mask byte
   sequence s_locked_write;
      host_wr && !level2_access && !nv_restore && host_addr == apm_pkg::GATE_MEAS_OFS;
   endsequence

   property p_gate_temp;
      @(posedge core_clk) disable iff (!arst_n)
         gate_pin_measure_mask[7] && temp_alarm |=> shutdown_gate_pin;
   endproperty
   a_gate_temp: assert property (p_gate_temp) else $error("temp alarm missed gate pin");

   property p_gate_vcc_mon1;
      @(posedge core_clk) disable iff (!arst_n)
         (gate_pin_measure_mask[6] && vcc_alarm) || (gate_pin_measure_mask[5] && mon1_alarm)
         |=> shutdown_gate_pin;
   endproperty
   a_gate_vcc_mon1: assert property (p_gate_vcc_mon1) else $error("vcc/mon1 gate");

   property p_gate_mon234;
      @(posedge core_clk) disable iff (!arst_n)
         (gate_pin_measure_mask[4] && mon2_alarm) || (gate_pin_measure_mask[3] && mon3_alarm)
         || (gate_pin_measure_mask[2] && mon4_alarm) |=> shutdown_gate_pin;
   endproperty
   a_gate_mon234: assert property (p_gate_mon234) else $error("mon2-4 gate");

   property p_gate_fast;
      @(posedge core_clk) disable iff (!arst_n)
         |(gate_pin_fast_mask & fast_vec) |=> shutdown_gate_pin;
   endproperty
   a_gate_fast: assert property (p_gate_fast) else $error("fast alarm lost");

   property p_reserved_zero;
      @(posedge core_clk) disable iff (!arst_n)
         gate_pin_measure_mask[1:0] == 2'h0 && gate_pin_fast_mask[3:0] == 4'h0
         && fault_pin_measure_mask[1:0] == 2'h0;
   endproperty
   a_reserved_zero: assert property (p_reserved_zero) else $error("reserved bit set");

   property p_fault_meas;
      @(posedge core_clk) disable iff (!arst_n)
         |(fault_pin_measure_mask & meas_vec) |=> fault_pin;
   endproperty
   a_fault_meas: assert property (p_fault_meas) else $error("fault alarm lost");

   // Fault pin stays low unless an enabled slow alarm is up
   property p_fault_only_enabled;
      @(posedge core_clk) disable iff (!arst_n)
         !(|(fault_pin_measure_mask & meas_vec)) |=> !fault_pin;
   endproperty
   a_fault_only_enabled: assert property (p_fault_only_enabled)
      else $error("fault pin unmasked");

   property p_pins_only_enabled;
      @(posedge core_clk) disable iff (!arst_n)
         !(|(gate_pin_measure_mask & meas_vec)) && !(|(gate_pin_fast_mask & fast_vec))
         |=> !shutdown_gate_pin;
   endproperty
   a_pins_only_enabled: assert property (p_pins_only_enabled)
      else $error("gate unmasked");

   property p_locked_write;
      @(posedge core_clk) disable iff (!arst_n)
         s_locked_write |=> $stable(gate_pin_measure_mask);
   endproperty
   a_locked_write: assert property (p_locked_write) else $error("locked write landed");

   property p_nv_restore;
      @(posedge core_clk) disable iff (!arst_n)
         nv_restore |=> gate_pin_fast_mask == ($past(nv_gate_fast) & apm_pkg::FAST_WMASK);
   endproperty
   a_nv_restore: assert property (p_nv_restore) else $error("nv reload lost");
endmodule

/* File: core/apm_pin_drive.sv */
`timescale 1ns/1ps
// One fault pin: masked OR of measurement and fast alarms, one flop deep
module apm_pin_drive (
   input wire logic core_clk, // Device clock
   input wire logic arst_n, // Async reset, active low
   input wire logic [7:0] meas_mask, // Measurement enables
   input wire logic [7:0] fast_mask, // Fast-comparator enables
   input wire logic [7:0] meas_alarm, // Measurement alarms, mask-aligned
   input wire logic [7:0] fast_alarm, // Fast alarms, mask-aligned
   output logic pin // Fault pin level
);
   // Follows the alarms with no latching; the flop only keeps the pin glitch free
   always_ff @(posedge core_clk or negedge arst_n) begin
      if (!arst_n) begin
         pin <= 1'b0;
      end else begin
         pin <= apm_pkg::apm_masked_any(meas_mask, meas_alarm, apm_pkg::MEAS_WMASK)
              | apm_pkg::apm_masked_any(fast_mask, fast_alarm, apm_pkg::FAST_WMASK);
      end
   end
endmodule

/* File: core/apm_pkg.sv */
package apm_pkg;
   // Byte offsets of the mask bytes
   localparam logic [7:0] GATE_MEAS_OFS = 8'hb8;
   localparam logic [7:0] GATE_FAST_OFS = 8'hb9;
   localparam logic [7:0] FAULT_MEAS_OFS = 8'hba;
   // Stored level-2 password, four bytes from this base, high byte first
   localparam logic [7:0] STORED_PW_OFS = 8'hb4;
   // Password entry, four bytes from this base, high byte first
   localparam logic [7:0] ENTRY_BASE_OFS = 8'h7b;
   // Reset values
   localparam logic [7:0] MASK_RESET = 8'h00;
   localparam logic [31:0] PW_RESET = 32'hffff_ffff;
   localparam logic [7:0] READ_ZERO = 8'h00;
   // Writable bits; the rest are reserved and stay zero
   localparam logic [7:0] MEAS_WMASK = 8'hfc;
   localparam logic [7:0] FAST_WMASK = 8'hf0;
   // Alarm bit positions inside the measurement byte
   localparam int TEMP_BIT = 7;
   localparam int VCC_BIT = 6;
   localparam int MON1_BIT = 5;
   localparam int MON2_BIT = 4;
   localparam int MON3_BIT = 3;
   localparam int MON4_BIT = 2;
   // Alarm bit positions inside the fast-comparator byte
   localparam int HIGH_POWER_BIT = 7;
   localparam int LOW_POWER_BIT = 6;
   localparam int BIAS_HIGH_BIT = 5;
   localparam int BIAS_MAX_BIT = 4;

   // OR of all alarms whose enable is set; reserved bits never count
   function automatic logic apm_masked_any(input logic [7:0] mask, input logic [7:0] alarm,
                                            input logic [7:0] wmask);
      apm_masked_any = |(mask & alarm & wmask);
   endfunction
endpackage

/* File: tb/apm_host_model.sv */
`timescale 1ns/1ps
// Host on the register port: strobes change just after an edge
module apm_host_model (
   input wire logic core_clk, // Device clock
   output logic host_wr, // Write strobe
   output logic host_rd, // Read strobe
   output logic [7:0] host_addr, // Byte address
   output logic [7:0] host_wdata, // Write byte
   input wire logic [7:0] host_rdata, // Read byte
   input wire logic host_rvalid // Read byte valid
);
   // Idle bus at time zero
   initial begin
      host_wr = 1'b0;
      host_rd = 1'b0;
      host_addr = 8'h00;
      host_wdata = 8'h00;
   end
   // One byte write; data scrambled once released so stale values never help
   task automatic wr_byte(input logic [7:0] a, input logic [7:0] d);
      @(posedge core_clk);
      host_wr <= 1'b1;
      host_addr <= a;
      host_wdata <= d;
      @(posedge core_clk);
      host_wr <= 1'b0;
      host_wdata <= ~d;
   endtask
   // One byte read; answer looked at in the cycle it stands
   task automatic rd_byte(input logic [7:0] a, output logic [7:0] d, output logic v);
      @(posedge core_clk);
      host_rd <= 1'b1;
      host_addr <= a;
      @(posedge core_clk);
      host_rd <= 1'b0;
      #1;
      d = host_rdata;
      v = host_rvalid;
   endtask
   // Password entry, high byte first, four byte writes from ENTRY_BASE_OFS up
   task automatic enter_pw(input logic [31:0] pw);
      for (int k = 0; k < 4; k++) begin
         wr_byte(apm_pkg::ENTRY_BASE_OFS + 8'(k), pw[31-8*k -: 8]);
      end
   endtask
endmodule

/* File: tb/tb.sv */
`timescale 1ns/1ps
module tb;
   logic core_clk; // Device clock
   logic arst_n; // Async reset, active low
   logic host_wr, host_rd, host_rvalid, level2_access; // Register port
   logic [7:0] host_addr, host_wdata, host_rdata; // Register port bytes
   logic [7:0] meas_al; // Slow alarms, aligned to the measurement masks
   logic [3:0] fast_al; // Fast alarms, aligned to fast mask bits 7:4
   logic nv_restore; // Reload pulse
   logic [7:0] nv_gm, nv_gf, nv_fm; // Stored images
   logic shutdown_gate_pin, fault_pin; // Fault pins
   int err_count;
   int cmp_count;
   apm_host_model u_host (.core_clk(core_clk), .host_wr(host_wr), .host_rd(host_rd),
      .host_addr(host_addr), .host_wdata(host_wdata), .host_rdata(host_rdata),
      .host_rvalid(host_rvalid));
   apm_alarm_mask u_apm_alarm_mask (.core_clk(core_clk), .arst_n(arst_n),
      .host_wr(host_wr), .host_rd(host_rd), .host_addr(host_addr),
      .host_wdata(host_wdata), .host_rdata(host_rdata), .host_rvalid(host_rvalid),
      .level2_access(level2_access), .temp_alarm(meas_al[7]), .vcc_alarm(meas_al[6]),
      .mon1_alarm(meas_al[5]), .mon2_alarm(meas_al[4]), .mon3_alarm(meas_al[3]),
      .mon4_alarm(meas_al[2]), .high_power_alarm(fast_al[3]),
      .low_power_alarm(fast_al[2]), .bias_high_alarm(fast_al[1]),
      .bias_max_alarm(fast_al[0]), .nv_restore(nv_restore), .nv_gate_meas(nv_gm),
      .nv_gate_fast(nv_gf), .nv_fault_meas(nv_fm),
      .shutdown_gate_pin(shutdown_gate_pin), .fault_pin(fault_pin));
   // Free-running 100 MHz clock
   initial begin
      core_clk = 1'b0;
      forever #5 core_clk = ~core_clk;
   end
   task automatic check(input string what, input logic [7:0] exp, input logic [7:0] got);
      cmp_count++;
      if (got !== exp) begin
         err_count++;
         $display("unexpected %s: expected %h, seen %h", what, exp, got);
      end
   endtask
   task automatic rd_chk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      logic v;
      u_host.rd_byte(a, d, v);
      check("host_rvalid", 8'h01, {7'h00, v});
      check("host_rdata", exp, d);
   endtask
   // Pins settle one cycle after the alarms change
   task automatic pins(input logic [7:0] m, input logic [3:0] f, input logic g, input logic t);
      @(posedge core_clk);
      meas_al <= m;
      fast_al <= f;
      repeat (2) @(posedge core_clk);
      #1;
      check("shutdown_gate_pin", {7'h00, g}, {7'h00, shutdown_gate_pin});
      check("fault_pin", {7'h00, t}, {7'h00, fault_pin});
   endtask
   task automatic sc_reset();
      check("level2_access", 8'h01, {7'h00, level2_access});
      rd_chk(apm_pkg::GATE_MEAS_OFS, 8'h00);
      rd_chk(apm_pkg::GATE_FAST_OFS, 8'h00);
      rd_chk(apm_pkg::FAULT_MEAS_OFS, 8'h00);
      pins(8'hff, 4'hf, 1'b0, 1'b0);
   endtask
   task automatic sc_route();
      logic [7:0] b;
      for (int i = 2; i < 8; i++) begin
         b = 8'h01 << i;
         u_host.wr_byte(apm_pkg::GATE_MEAS_OFS, b);
         u_host.wr_byte(apm_pkg::FAULT_MEAS_OFS, 8'h00);
         pins(~b, 4'h0, 1'b0, 1'b0);
         pins(b, 4'hf, 1'b1, 1'b0);
         u_host.wr_byte(apm_pkg::GATE_MEAS_OFS, 8'h00);
         u_host.wr_byte(apm_pkg::FAULT_MEAS_OFS, b);
         pins(b, 4'h0, 1'b0, 1'b1);
         pins(~b, 4'hf, 1'b0, 1'b0);
      end
      u_host.wr_byte(apm_pkg::FAULT_MEAS_OFS, 8'h00);
      for (int j = 4; j < 8; j++) begin
         b = 8'h01 << j;
         u_host.wr_byte(apm_pkg::GATE_FAST_OFS, b);
         pins(8'hff, ~b[7:4], 1'b0, 1'b0);
         pins(8'h00, b[7:4], 1'b1, 1'b0);
      end
   endtask
   task automatic sc_reserved();
      u_host.wr_byte(apm_pkg::GATE_MEAS_OFS, 8'hff);
      u_host.wr_byte(apm_pkg::GATE_FAST_OFS, 8'hff);
      u_host.wr_byte(apm_pkg::FAULT_MEAS_OFS, 8'hff);
      rd_chk(apm_pkg::GATE_MEAS_OFS, 8'hfc);
      rd_chk(apm_pkg::GATE_FAST_OFS, 8'hf0);
      rd_chk(apm_pkg::FAULT_MEAS_OFS, 8'hfc);
      pins(8'h03, 4'h0, 1'b0, 1'b0);
      pins(8'h04, 4'h0, 1'b1, 1'b1);
   endtask
   // Wrong entry locks the masks; matching entry opens them again
   task automatic sc_password();
      u_host.wr_byte(apm_pkg::GATE_MEAS_OFS, 8'h44);
      u_host.enter_pw(32'h1234_5678);
      repeat (2) @(posedge core_clk);
      #1;
      check("level2_access", 8'h00, {7'h00, level2_access});
      u_host.wr_byte(apm_pkg::GATE_MEAS_OFS, 8'h80);
      rd_chk(apm_pkg::GATE_MEAS_OFS, 8'h00);
      u_host.enter_pw(32'hffff_ffff);
      repeat (2) @(posedge core_clk);
      #1;
      check("level2_access", 8'h01, {7'h00, level2_access});
      rd_chk(apm_pkg::GATE_MEAS_OFS, 8'h44);
      rd_chk(apm_pkg::STORED_PW_OFS, 8'h00);
      rd_chk(apm_pkg::ENTRY_BASE_OFS, 8'h00);
      rd_chk(8'hc0, 8'h00);
      // Changing the stored password locks until the entry matches it
      u_host.wr_byte(apm_pkg::STORED_PW_OFS, 8'h12);
      repeat (2) @(posedge core_clk);
      #1;
      check("level2_access", 8'h00, {7'h00, level2_access});
      u_host.enter_pw(32'h12ff_ffff);
      repeat (2) @(posedge core_clk);
      #1;
      check("level2_access", 8'h01, {7'h00, level2_access});
      u_host.wr_byte(apm_pkg::STORED_PW_OFS, 8'hff);
      u_host.enter_pw(32'hffff_ffff);
      repeat (2) @(posedge core_clk);
      #1;
      check("level2_access", 8'h01, {7'h00, level2_access});
   endtask
   // Mid-run reset: masks loaded earlier must clear again
   task automatic sc_rerst();
      @(posedge core_clk);
      arst_n <= 1'b0;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      sc_reset();
   endtask
   task automatic sc_nv();
      @(posedge core_clk);
      nv_gm <= 8'h83;
      nv_gf <= 8'h1f;
      nv_fm <= 8'h07;
      nv_restore <= 1'b1;
      @(posedge core_clk);
      nv_restore <= 1'b0;
      rd_chk(apm_pkg::GATE_MEAS_OFS, 8'h80);
      rd_chk(apm_pkg::GATE_FAST_OFS, 8'h10);
      rd_chk(apm_pkg::FAULT_MEAS_OFS, 8'h04);
      pins(8'h80, 4'h0, 1'b1, 1'b0);
      pins(8'h04, 4'h1, 1'b1, 1'b1);
   endtask
   task automatic close_out();
      $display("errors %0d, comparisons %0d", err_count, cmp_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("TB: PASS");
      end else begin
         $display("TB: FAIL");
      end
      $finish;
   endtask
   // Hang guard
   initial begin
      #200000;
      err_count++;
      close_out();
   end
   // Main sequence
   initial begin
      err_count = 0;
      cmp_count = 0;
      arst_n = 1'b0;
      meas_al = 8'h00;
      fast_al = 4'h0;
      nv_restore = 1'b0;
      nv_gm = 8'h00;
      nv_gf = 8'h00;
      nv_fm = 8'h00;
      repeat (2) @(posedge core_clk);
      arst_n <= 1'b1;
      repeat (2) @(posedge core_clk);
      #1;
      sc_reset();
      sc_route();
      sc_reserved();
      sc_password();
      sc_nv();
      sc_rerst();
      close_out();
   end
endmodule
